/* core/scsr_pkg.sv */
// shared constants and helpers for the spi control and status block
package scsr_pkg;
  localparam int SCSR_AW = 12;
  localparam int SCSR_DW = 32;

  // register byte offsets
  localparam logic [SCSR_AW-1:0] SCSR_OFF_DATA = 12'h000;
  localparam logic [SCSR_AW-1:0] SCSR_OFF_CTRL = 12'h004;
  localparam logic [SCSR_AW-1:0] SCSR_OFF_STAT = 12'h008;

  // spi_control fields
  localparam int SCSR_C_IRQ_EN = 7;
  localparam int SCSR_C_SPE = 6;
  localparam int SCSR_C_BYPASS = 5;
  localparam int SCSR_C_MASTER_SELECT = 4;
  localparam int SCSR_C_CLOCK_IDLE_POLARITY = 3;
  localparam int SCSR_C_CLOCK_PHASE_SELECT = 2;
  localparam int SCSR_C_RATE_HI = 1;
  localparam int SCSR_C_RATE_LO = 0;

  // spi_control_status fields
  localparam int SCSR_S_DONE = 7;
  localparam int SCSR_S_WRITE_COLLISION_FLAG = 6;
  localparam int SCSR_S_OVR = 5;
  localparam int SCSR_S_MODE_FAULT_FLAG = 4;
  localparam int SCSR_S_RSVD = 3;
  localparam int SCSR_S_SOD = 2;
  localparam int SCSR_S_SSM = 1;
  localparam int SCSR_S_SSI = 0;

  localparam logic [7:0] SCSR_CTRL_RST = 8'h00;
  localparam logic [7:0] SCSR_STAT_RST = 8'h00;
  localparam logic [2:0] SCSR_SW_RST = 3'h0;
  localparam logic [7:0] SCSR_DATA_RST = 8'h00;

  // a byte takes sixteen sck transitions
  localparam logic [3:0] SCSR_EDGE_LAST = 4'hF;

  // master sck division ratios of the cpu clock
  localparam logic [7:0] SCSR_DIV_4 = 8'h04;
  localparam logic [7:0] SCSR_DIV_8 = 8'h08;
  localparam logic [7:0] SCSR_DIV_16 = 8'h10;
  localparam logic [7:0] SCSR_DIV_32 = 8'h20;
  localparam logic [7:0] SCSR_DIV_64 = 8'h40;
  localparam logic [7:0] SCSR_DIV_128 = 8'h80;

  typedef enum logic {SCSR_IDLE, SCSR_RUN} scsr_xfer_e;

  // half sck period in cpu cycles; bypass drops the extra divide by two
  function automatic logic [6:0] scsr_half(input logic bypass, input logic [1:0] sel);
    logic [7:0] ratio;
    ratio = SCSR_DIV_8;
    case ({bypass, sel})
      3'h4: ratio = SCSR_DIV_4;
      3'h0: ratio = SCSR_DIV_8;
      3'h1: ratio = SCSR_DIV_16;
      3'h5: ratio = SCSR_DIV_8;
      3'h6: ratio = SCSR_DIV_32;
      3'h2: ratio = SCSR_DIV_64;
      3'h3: ratio = SCSR_DIV_128;
      3'h7: ratio = SCSR_DIV_64;
      default: ratio = SCSR_DIV_8;
    endcase
    return ratio[7:1];
  endfunction
endpackage

/* core/scsr_sck_div.sv */
// half-period tick generator for the master serial clock
`timescale 1ns/10ps
module scsr_sck_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [6:0] i_half,
  output logic o_tick
);
  logic [6:0] cnt_q;

  // counting restarts with every byte so the first edge follows a full half period
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      cnt_q <= 7'h00;
      o_tick <= 1'b0;
    end else if (cnt_q == i_half - 7'h01) begin
      cnt_q <= 7'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

/* core/scsr_top.sv */
// spi control and status registers with byte shifter, apb slave and pin control
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
// Functional notes
// - irq request when irq enable set and done, overrun or mode fault flag set
// - peripheral enable cleared by reset, and with master select on mode fault
// - enable 0 leaves pins general purpose; 1 connects spi pin functions
// - master sck ratio from bypass and rate select: /4 to /128
// - rate select bits unused in slave mode
// - master select drives sck and swaps mosi and miso roles
// - clock polarity sets sck idle level
// - clock phase picks first or second transition for first capture
// - done flag sets at byte end; cleared by status read then data access
// - data writes ignored while done is set until status read
// - write collision sets on data write during a transfer
// - overrun sets when a byte completes while done still set
// - status read clears overrun
// - mode fault sets when slave select low in master mode
// - mode fault clears by status or control read while set then control write
// - output disable disconnects data output; else enabled with peripheral enable, for a slave only while selected
// - software select mode ignores select pin and frees it
// - internal select level 0 selects, 1 deselects
// - write collision never requests an interrupt
// - master data write starts the next byte
module scsr_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [scsr_pkg::SCSR_AW-1:0] i_paddr,
  input wire logic [scsr_pkg::SCSR_DW-1:0] i_pwdata,
  output logic [scsr_pkg::SCSR_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_ss_n,
  output logic o_ss_pin_free,
  output logic o_alt_func_en,
  output logic o_irq
);
  import scsr_pkg::*;

  logic [7:0] ctrl_q;
  logic [2:0] sw_q;
  logic done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q;
  logic arm_q, mode_fault_flag_arm_q;
  logic [1:0] sck_sync_q, ss_sync_q, mosi_sync_q, miso_sync_q;
  logic sck_prev_q;
  scsr_xfer_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, rxbuf_q;
  logic rx_bit_q;
  logic sck_q;
  logic tick;

  // second synchroniser stage is the only one the logic reads
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sck_sync_q <= 2'h0;
      ss_sync_q <= 2'h3;
      mosi_sync_q <= 2'h0;
      miso_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_sync_q <= {sck_sync_q[0], i_sck};
      ss_sync_q <= {ss_sync_q[0], i_ss_n};
      mosi_sync_q <= {mosi_sync_q[0], i_mosi};
      miso_sync_q <= {miso_sync_q[0], i_miso};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  logic peripheral_enable_bit, master_select, clock_phase_select, ss_int, din, master_run, active;
  assign peripheral_enable_bit = ctrl_q[SCSR_C_SPE];
  assign master_select = ctrl_q[SCSR_C_MASTER_SELECT];
  assign clock_phase_select = ctrl_q[SCSR_C_CLOCK_PHASE_SELECT];
  assign ss_int = sw_q[SCSR_S_SSM] ? sw_q[SCSR_S_SSI] : ss_sync_q[1];
  assign din = master_select ? miso_sync_q[1] : mosi_sync_q[1];
  assign master_run = (st_q == SCSR_RUN) && master_select;
  assign active = master_run || ((st_q == SCSR_RUN) && (cnt_q != 4'h0));

  // apb decode; every access finishes in one access cycle
  logic setup, acc, wr_data, rd_data, wr_ctrl, rd_ctrl, rd_stat, wr_stat, mapped;
  assign setup = i_psel && !i_penable;
  assign acc = i_psel && i_penable && o_pready;
  assign wr_data = acc && i_pwrite && (i_paddr == SCSR_OFF_DATA);
  assign rd_data = acc && !i_pwrite && (i_paddr == SCSR_OFF_DATA);
  assign wr_ctrl = acc && i_pwrite && (i_paddr == SCSR_OFF_CTRL);
  assign rd_ctrl = acc && !i_pwrite && (i_paddr == SCSR_OFF_CTRL);
  assign wr_stat = acc && i_pwrite && (i_paddr == SCSR_OFF_STAT);
  assign rd_stat = acc && !i_pwrite && (i_paddr == SCSR_OFF_STAT);
  assign mapped = (i_paddr == SCSR_OFF_DATA) || (i_paddr == SCSR_OFF_CTRL) ||
                  (i_paddr == SCSR_OFF_STAT);

  logic [7:0] stat_rd;
  logic [SCSR_DW-1:0] rd_word;
  always_comb begin
    stat_rd = 8'h00;
    stat_rd[SCSR_S_DONE] = done_q;
    stat_rd[SCSR_S_WRITE_COLLISION_FLAG] = write_collision_flag_q;
    stat_rd[SCSR_S_OVR] = ovr_q;
    stat_rd[SCSR_S_MODE_FAULT_FLAG] = mode_fault_flag_q;
    stat_rd[SCSR_S_SOD:SCSR_S_SSI] = sw_q;
    case (i_paddr)
      SCSR_OFF_DATA: rd_word = {24'h000000, rxbuf_q};
      SCSR_OFF_CTRL: rd_word = {24'h000000, ctrl_q};
      SCSR_OFF_STAT: rd_word = {24'h000000, stat_rd};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup) begin
        o_prdata <= rd_word;
      end
    end
  end

  // event terms shared by flags and shifter
  logic fault_now, collide, accept, edge_ev, last_edge, complete, quit, cap_q, fin_q;
  logic [7:0] rx_byte;
  assign fault_now = peripheral_enable_bit && master_select && !ss_int;
  assign collide = wr_data && active;
  assign accept = wr_data && !active && (!done_q || arm_q);
  assign edge_ev = master_select ? tick : (sck_sync_q[1] ^ sck_prev_q);
  assign last_edge = (cnt_q == SCSR_EDGE_LAST);
  assign quit = !peripheral_enable_bit || (!master_select && ss_int);
  assign complete = (st_q == SCSR_RUN) && !quit && ((edge_ev && last_edge && !clock_phase_select) || fin_q);
  assign rx_byte = clock_phase_select ? {sh_q[6:0], din} : {sh_q[6:0], rx_bit_q};

  // control register; fault clears enable and master, and writes cannot set them again until the fault flag is armed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= SCSR_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_pwdata[7:0];
        if (mode_fault_flag_q && !mode_fault_flag_arm_q) begin
          ctrl_q[SCSR_C_SPE] <= 1'b0;
          ctrl_q[SCSR_C_MASTER_SELECT] <= 1'b0;
        end
      end
      if (fault_now) begin
        ctrl_q[SCSR_C_SPE] <= 1'b0;
        ctrl_q[SCSR_C_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  // software-owned status bits; the reserved bit is not stored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sw_q <= SCSR_SW_RST;
    end else if (wr_stat) begin
      sw_q <= i_pwdata[SCSR_S_SOD:SCSR_S_SSI];
    end
  end

  // hardware flags; a set in the same cycle as its clear wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      arm_q <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else begin
      if (rd_stat) begin
        arm_q <= 1'b1;
      end else if (rd_data || wr_data) begin
        arm_q <= 1'b0;
      end
      if (complete) begin
        done_q <= 1'b1;
      end else if ((rd_data || wr_data) && arm_q) begin
        done_q <= 1'b0;
      end
      if (collide) begin
        write_collision_flag_q <= 1'b1;
      end else if (rd_data && arm_q) begin
        write_collision_flag_q <= 1'b0;
      end
      if (complete && done_q) begin
        ovr_q <= 1'b1;
      end else if (rd_stat) begin
        ovr_q <= 1'b0;
      end
      if (fault_now) begin
        mode_fault_flag_q <= 1'b1;
      end else if (wr_ctrl && mode_fault_flag_arm_q) begin
        mode_fault_flag_q <= 1'b0;
      end
      if ((rd_stat || rd_ctrl) && mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;
      end else if (wr_ctrl) begin
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // the divider only runs for a master byte; slave rate bits are never looked at
  scsr_sck_div u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(master_run),
    .i_half(scsr_half(ctrl_q[SCSR_C_BYPASS], ctrl_q[SCSR_C_RATE_HI:SCSR_C_RATE_LO])),
    .o_tick(tick)
  );

  // data inputs lag two flops, so a capture takes din one cycle after its edge;
  // a phase 1 byte ends on a capture edge and so completes one cycle late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cap_q <= 1'b0;
      fin_q <= 1'b0;
    end else begin
      cap_q <= (st_q == SCSR_RUN) && edge_ev && (cnt_q[0] == clock_phase_select);
      fin_q <= (st_q == SCSR_RUN) && !quit && edge_ev && last_edge && clock_phase_select;
    end
  end

  // byte shifter shared by master and slave
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= SCSR_IDLE;
      cnt_q <= 4'h0;
      sh_q <= SCSR_DATA_RST;
      rxbuf_q <= SCSR_DATA_RST;
      rx_bit_q <= 1'b0;
    end else begin
      if (cap_q) begin
        rx_bit_q <= din;
      end
      case (st_q)
        SCSR_IDLE: begin
          cnt_q <= 4'h0;
          if (accept) begin
            sh_q <= i_pwdata[7:0];
          end
          if (accept && peripheral_enable_bit && master_select) begin
            st_q <= SCSR_RUN;
          end else if (peripheral_enable_bit && !master_select && !ss_int) begin
            st_q <= SCSR_RUN;
          end
        end
        SCSR_RUN: begin
          if (quit) begin
            st_q <= SCSR_IDLE;
          end else if (complete) begin
            cnt_q <= 4'h0;
            sh_q <= rx_byte;
            if (!done_q) begin
              rxbuf_q <= rx_byte;
            end
            if (master_select) begin
              st_q <= SCSR_IDLE;
            end
          end else if (edge_ev) begin
            if (!last_edge) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if ((cnt_q[0] != clock_phase_select) && !(clock_phase_select && cnt_q == 4'h0)) begin
              sh_q <= {sh_q[6:0], rx_bit_q};
            end
          end else if (accept && !master_select) begin
            sh_q <= i_pwdata[7:0];
          end
        end
        default: st_q <= SCSR_IDLE;
      endcase
    end
  end

  // master clock rests at the polarity level between bytes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sck_q <= 1'b0;
    end else if (!master_run) begin
      sck_q <= ctrl_q[SCSR_C_CLOCK_IDLE_POLARITY];
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end

  // pin control registered so every pin output is a flop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sck_oe <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso_oe <= 1'b0;
      o_alt_func_en <= 1'b0;
      o_ss_pin_free <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_sck_oe <= peripheral_enable_bit && master_select;
      o_mosi_oe <= peripheral_enable_bit && master_select && !sw_q[SCSR_S_SOD];
      // an unselected slave keeps off miso so several slaves can share it
      o_miso_oe <= peripheral_enable_bit && !master_select && !sw_q[SCSR_S_SOD] && !ss_int;
      o_alt_func_en <= peripheral_enable_bit;
      o_ss_pin_free <= sw_q[SCSR_S_SSM];
      o_irq <= ctrl_q[SCSR_C_IRQ_EN] && (done_q || ovr_q || mode_fault_flag_q);
    end
  end

  assign o_sck = sck_q;
  assign o_mosi = sh_q[7];
  assign o_miso = sh_q[7];

  // helper: cycles between master half-period ticks
  logic [7:0] gap_q;
  logic seen_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || !master_run) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (tick) begin
      gap_q <= 8'h01;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end

  sequence s_start;
    accept && peripheral_enable_bit && master_select && (st_q == SCSR_IDLE);
  endsequence
  sequence s_byte_end;
    complete && !done_q;
  endsequence

  property p_irq_gate;
    @(posedge i_clk) disable iff (i_rst)
    (ctrl_q[SCSR_C_IRQ_EN] && (ovr_q || mode_fault_flag_q || done_q)) |=> o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq missing with flag set");

  property p_irq_write_collision_flag;
    @(posedge i_clk) disable iff (i_rst)
    (!done_q && !ovr_q && !mode_fault_flag_q) |=> !o_irq;
  endproperty
  a_irq_write_collision_flag: assert property (p_irq_write_collision_flag) else $error("irq without cause");

  property p_fault;
    @(posedge i_clk) disable iff (i_rst)
    fault_now |=> (mode_fault_flag_q && !peripheral_enable_bit && !master_select) ##2 !o_sck_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault effects wrong");

  property p_rate;
    @(posedge i_clk) disable iff (i_rst)
    (tick && seen_q) |-> ({1'b0, u_div.i_half} == gap_q);
  endproperty
  a_rate: assert property (p_rate) else $error("sck half period wrong");

  property p_start;
    @(posedge i_clk) disable iff (i_rst)
    s_start |=> master_run ##1 (sck_q == ctrl_q[SCSR_C_CLOCK_IDLE_POLARITY]);
  endproperty
  a_start: assert property (p_start) else $error("master write did not start");

  property p_ignore;
    @(posedge i_clk) disable iff (i_rst)
    (wr_data && done_q && !arm_q && st_q == SCSR_IDLE) |=> $stable(sh_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("write taken while done set");

  property p_collide;
    @(posedge i_clk) disable iff (i_rst)
    (wr_data && active && !edge_ev && !complete) |=> (write_collision_flag_q && $stable(sh_q[7]));
  endproperty
  a_collide: assert property (p_collide) else $error("collision not flagged");

  property p_done;
    @(posedge i_clk) disable iff (i_rst)
    s_byte_end |=> (done_q && rxbuf_q == sh_q);
  endproperty
  a_done: assert property (p_done) else $error("byte end not flagged");

  property p_overrun;
    @(posedge i_clk) disable iff (i_rst)
    (complete && done_q) |=> (ovr_q && $stable(rxbuf_q));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_ovr_clear;
    @(posedge i_clk) disable iff (i_rst)
    (rd_stat && !complete) |=> !ovr_q;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

  property p_mode_fault_flag_keep;
    @(posedge i_clk) disable iff (i_rst)
    (wr_ctrl && mode_fault_flag_q && !mode_fault_flag_arm_q) |=> (mode_fault_flag_q && !peripheral_enable_bit);
  endproperty
  a_mode_fault_flag_keep: assert property (p_mode_fault_flag_keep) else $error("mode fault cleared early");
endmodule

/* sim/scsr_far_slave.sv */
// behavioural far-side spi slave, used while the block is master
`timescale 1ns/10ps
module scsr_far_slave (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  input wire logic i_clock_idle_polarity,
  input wire logic i_clock_phase_select,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic [7:0] sh;
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
    sh = 8'h00;
  end
  // a released line must not keep showing the last bit
  always @(posedge i_ss_n) o_miso = ~o_miso;
  always @(negedge i_ss_n) begin
    sh = i_tx;
    if (!i_clock_phase_select) begin
      o_miso = sh[7];
      sh = sh << 1;
    end
  end
  // same polarity and phase settings as the master
  always @(i_sck) begin
    if (!i_ss_n) begin
      if ((i_sck != i_clock_idle_polarity) ^ i_clock_phase_select) begin
        o_rx = {o_rx[6:0], i_mosi};
      end else begin
        o_miso = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule

/* sim/scsr_top_tb.sv */
// self-checking bench for the spi control and status block
`timescale 1ns/10ps
module scsr_top_tb;
  import scsr_pkg::*;
  localparam logic [11:0] AC = SCSR_OFF_CTRL;
  localparam logic [11:0] AS = SCSR_OFF_STAT;
  localparam logic [11:0] AD = SCSR_OFF_DATA;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, lsck, lmosi, ss_n, sss_n;
  logic sck, sck_oe, mosi, mosi_oe, miso, miso_oe, pin_free, alt_en, irq, smiso;
  logic clock_idle_polarity, clock_phase_select, sck_d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] stx, srx, g;
  logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  int halves [6] = '{2, 4, 8, 16, 32, 64};
  int bad_count, compares, tog, gap, since;
  wire sck_w = sck_oe ? sck : lsck;
  wire mosi_w = mosi_oe ? mosi : lmosi;
  wire miso_w = miso_oe ? miso : smiso;

  scsr_top u_scsr_top (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe), .i_mosi(mosi_w),
    .o_mosi(mosi), .o_mosi_oe(mosi_oe), .i_miso(miso_w), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_ss_n(ss_n), .o_ss_pin_free(pin_free),
    .o_alt_func_en(alt_en), .o_irq(irq)
  );
  scsr_far_slave u_scsr_far_slave (
    .i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(sss_n), .i_clock_idle_polarity(clock_idle_polarity), .i_clock_phase_select(clock_phase_select),
    .i_tx(stx), .o_miso(smiso), .o_rx(srx)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // toggle count and spacing of the master clock, in cpu cycles
  always @(posedge clk) begin
    sck_d <= sck;
    since <= since + 1;
    if (sck !== sck_d) begin
      tog <= tog + 1;
      gap <= since;
      since <= 1;
    end
  end

  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    compares++;
    if (gv !== ev) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  task automatic chb(input logic gv, input logic ev);
    chk({31'h0, gv}, {31'h0, ev});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    r = prdata;
    chb(pslverr, a == 12'h00C);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h000000, e});
  endtask
  task automatic wt(input int n);
    int k;
    k = 0;
    while (tog < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic mx(input logic [2:0] c, input logic [1:0] md, input int h,
                    input logic [7:0] tx, input logic [7:0] sb);
    int t0;
    sss_n <= 1'b1;
    w(AC, 8'h00);
    clock_idle_polarity <= md[1];
    clock_phase_select <= md[0];
    stx <= sb;
    w(AC, {2'h3, c[2], 1'b1, md, c[1:0]});
    cyc(3);
    sss_n <= 1'b0;
    chb(sck, md[1]);
    chb(sck_oe, 1'b1);
    chb(mosi_oe & ~miso_oe & alt_en, 1'b1);
    t0 = tog;
    w(AD, tx);
    wt(t0 + 16);
    cyc(4);
    chk(tog - t0, 16);
    chk(gap, h);
    chb(sck, md[1]);
    chb(irq, 1'b1);
    chk(srx, tx);
    rc(AS, 8'h80);
    rc(AD, sb);
    rc(AS, 8'h00);
    chb(irq, 1'b0);
  endtask

  task automatic ti();
    int t0;
    sss_n <= 1'b1;
    w(AC, 8'hF0);
    clock_idle_polarity <= 1'b0;
    clock_phase_select <= 1'b0;
    stx <= 8'h66;
    cyc(2);
    sss_n <= 1'b0;
    t0 = tog;
    w(AD, 8'h81);
    wt(t0 + 16);
    cyc(4);
    sss_n <= 1'b1;
    w(AD, 8'h42);
    cyc(20);
    chk(tog - t0, 16);
    rc(AS, 8'h80);
    sss_n <= 1'b0;
    t0 = tog;
    w(AD, 8'h42);
    w(AD, 8'h99);
    rc(AS, 8'h40);
    chb(irq, 1'b0);
    wt(t0 + 16);
    cyc(4);
    chk(srx, 8'h42);
    rc(AS, 8'hC0);
    rc(AD, 8'h66);
    rc(AS, 8'h00);
  endtask

  // bench acts as the far master: phase 0, idle low, 160 ns link period
  task automatic sb(input logic [7:0] tx, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      lmosi <= tx[i];
      cyc(20);
      got[i] = miso_w;
      lsck <= 1'b1;
      cyc(20);
      lsck <= 1'b0;
    end
    cyc(20);
    lmosi <= ~lmosi;
  endtask

  task automatic ts();
    w(AC, 8'h00);
    w(AS, 8'h02);
    w(AC, 8'hE3);
    w(AD, 8'h3C);
    cyc(4);
    chb(pin_free, 1'b1);
    chb(miso_oe & ~sck_oe & ~mosi_oe, 1'b1);
    sb(8'hA5, g);
    chk(g, 8'h3C);
    cyc(4);
    chb(irq, 1'b1);
    sb(8'h5A, g);
    cyc(4);
    rc(AS, 8'hA2);
    rc(AS, 8'h82);
    rc(AD, 8'hA5);
    w(AS, 8'h06);
    cyc(3);
    chb(miso_oe, 1'b0);
    w(AS, 8'h03);
    cyc(3);
    chb(miso_oe, 1'b0);
  endtask

  task automatic tm();
    w(AS, 8'h00);
    w(AC, 8'hD0);
    cyc(2);
    ss_n <= 1'b0;
    cyc(6);
    chb(irq & ~alt_en, 1'b1);
    ss_n <= 1'b1;
    cyc(4);
    w(AC, 8'h50);
    rc(AS, 8'h10);
    rc(AC, 8'h00);
    w(AC, 8'h00);
    rc(AS, 8'h00);
    chb(irq, 1'b0);
  endtask

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    finish_test();
  end

  initial begin
    {rst, ss_n, sss_n} = 3'h7;
    {psel, penable, pwrite, lsck, lmosi, clock_idle_polarity, clock_phase_select} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    stx = 8'h00;
    tog = 0;
    since = 0;
    gap = 0;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(AC, 8'h00);
    rc(AS, 8'h00);
    rc(12'h00C, 8'h00);
    chb(alt_en | sck_oe | irq, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      mx(codes[i], 2'(i), halves[i], 8'(8'h3C + i * 37), 8'(8'hC3 - i * 29));
    end
    $display("test master rates done");
    ti();
    $display("test collision done");
    ts();
    $display("test slave done");
    tm();
    $display("test mode fault done");
    finish_test();
  end
endmodule
